// ---- spi_slave_queue_access.sv ----
/*
 * Serial slave port with register and packet-queue access, plus the
 * transmit-queue frame walker and receive-queue byte feeder.
 * Assumes the master drives the serial clock only inside chip-select frames
 * and that the mac side sits on the system clock.
 */
// Behaviour
// [RULE1] sample input line on serial clock rise
// [RULE2] change output line on serial clock fall
// [RULE3] chip select frames and resets the decoder
// [RULE4] master keeps serial clock low when idle
// [RULE5] two opcode bits pick the operation
// [RULE6] register command two bytes, queue command one
// [RULE7] lane enables then dword address then spare
// [RULE8] enabled lanes only appear in data phase
// [RULE9] lane zero shifted first, lane three last
// [RULE10] queue command then streamed queue data
// [RULE11] queue data phase bounded by queue size
// [RULE12] host sets start-access bit around queue transfers
// [RULE13] 12K receive and 6K transmit packet memory
// [RULE14] frame: control, byte count, then data
// [RULE15] append checksum when crc generation enabled
// [RULE16] several frames may queue; status tracks current
// [RULE17] per-frame status in register at 0x72
// [RULE18] host writes one control word per packet
// [RULE19] control bit 15 requests done interrupt
// [RULE20] six-bit frame tag reported in status
// [RULE21] host gives correct nonzero byte count
// [RULE22] addresses and type field pass unchanged
// [RULE23] chip select rise ends queue data phase
// [RULE24] command bytes shifted msb first
`timescale 1ns/1ns
module spi_slave_queue_access
    import spi_queue_pkg::*;
#(
    parameter int TXQ_DEPTH = TXQ_BYTES,
    parameter int RXQ_DEPTH = RXQ_BYTES
) (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       SI,
    output      logic       SO,
    output      logic       SO_OE,
    input  wire logic [7:0] RX_BYTE,
    input  wire logic       RX_BYTE_VALID,
    output      logic       RX_ROOM,
    output      logic [7:0] TX_BYTE,
    output      logic       TX_BYTE_VALID,
    output      logic       TX_BYTE_LAST,
    input  wire logic       TX_BYTE_READY,
    output      logic       TX_DONE_IRQ_REQUEST
);
    localparam int TAW = $clog2(TXQ_DEPTH);
    localparam int RAW = $clog2(RXQ_DEPTH);

    // link side, cleared by every frame boundary
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [7:0] sh;
        spi_phase_t phase;
        logic [1:0] op;
        logic [3:0] be;
        logic [5:0] addr;
        logic [1:0] lane;
        logic [7:0] out_byte;
    } spi_t;

    // link side, survives frames
    typedef struct packed {
        logic [15:0] transmit_control_reg;
        logic [15:0] receive_queue_command_reg;
        logic        wr_tog;
        logic [7:0]  wr_byte;
        logic        take_tog;
        logic        st1;
        logic        st2;
        logic        st3;
        logic [15:0] stat;
    } cfg_t;

    typedef struct packed {
        logic so;
        logic so_oe;
    } pin_t;

    typedef struct packed {
        logic                    wt1;
        logic                    wt2;
        logic                    wt3;
        logic                    tk1;
        logic                    tk2;
        logic                    tk3;
        logic                    crc1;
        logic                    crc2;
        logic [TAW-1:0]          tx_wp;
        logic [TAW-1:0]          tx_rp;
        logic [TAW:0]            tx_cnt;
        tx_state_t               tx_state;
        logic [POS_WIDTH-1:0]    pos;
        logic [15:0]             ctrl;
        logic [LENGTH_WIDTH-1:0] len;
        logic [31:0]             crc;
        logic [1:0]              crc_idx;
        logic [7:0]              tx_byte;
        logic                    tx_valid;
        logic                    tx_last;
        logic                    irq;
        logic [15:0]             stat;
        logic                    stat_tog;
        logic [RAW-1:0]          rx_wp;
        logic [RAW-1:0]          rx_rp;
        logic [RAW:0]            rx_cnt;
        logic [7:0]              rx_stage;
        logic                    rx_full;
        logic                    rx_pend;
        logic                    rx_room;
    } core_t;

    spi_t  s, next_s;
    cfg_t  c, next_c;
    pin_t  p, next_p;
    core_t q, next_q;

    logic [7:0] tx_rdata;
    logic [7:0] rx_rdata;
    logic       tx_wr;
    logic       tx_rd;
    logic       rx_wr;
    logic       rx_rd;

    // first enabled lane at or above from; 3'd4 when none is left
    function automatic logic [2:0] first_lane(input logic [3:0] be, input logic [2:0] from);
        logic [2:0] f;
        f = 3'd4;
        for (int i = 3; i >= 0; i--) begin
            if (be[i] && (3'(i) >= from)) begin
                f = 3'(i);
            end
        end
        return f;
    endfunction : first_lane

    function automatic logic [7:0] reg_read(input logic [7:0] ba, input logic [15:0] transmit_control_reg,
                                            input logic [15:0] stat, input logic [15:0] receive_queue_command_reg);
        logic [15:0] w;
        w = {8'h00, UNMAPPED_READ};
        if (ba[7:1] == TX_CONTROL_OFFSET[7:1]) begin
            w = transmit_control_reg;
        end else if (ba[7:1] == TX_STATUS_OFFSET[7:1]) begin
            w = stat; // RULE17
        end else if (ba[7:1] == RXQ_COMMAND_OFFSET[7:1]) begin
            w = receive_queue_command_reg;
        end
        if (ba[7:1] != RXQ_COMMAND_OFFSET[7:1] && ba[7:1] != TX_CONTROL_OFFSET[7:1]
            && ba[7:1] != TX_STATUS_OFFSET[7:1]) begin
            return UNMAPPED_READ;
        end
        return ba[0] ? w[15:8] : w[7:0];
    endfunction : reg_read

    // link clock domain
    always_comb begin
        logic [7:0] nb;
        logic [7:0] ba;
        logic [2:0] f;
        logic       start;
        nb     = {s.sh[6:0], SI}; // RULE1 RULE24
        ba     = 8'h00;
        f      = 3'd4;
        start  = c.receive_queue_command_reg[START_ACCESS_BIT];
        next_s = s;
        next_c = c;
        next_s.sh      = nb;
        next_s.bit_cnt = s.bit_cnt + 3'd1;
        next_c.st1     = q.stat_tog;
        next_c.st2     = c.st1;
        next_c.st3     = c.st2;
        if (c.st3 != c.st2) begin
            next_c.stat = q.stat;
        end
        if (s.bit_cnt == 3'd7) begin
            case (s.phase)
                CMD_HI: begin
                    next_s.op = nb[7:6]; // RULE5
                    if (nb[7]) begin
                        next_s.phase = QUEUE_DATA; // RULE6 RULE10
                        if (nb[6:6] == OP_RXQ_READ[0:0] && start) begin // RULE12
                            next_s.out_byte = q.rx_stage;
                            next_c.take_tog = ~c.take_tog;
                        end
                    end else begin
                        next_s.be    = nb[5:2]; // RULE7
                        next_s.addr  = {nb[1:0], 4'h0};
                        next_s.phase = CMD_LO;
                    end
                end
                CMD_LO: begin
                    next_s.addr = {s.addr[5:4], nb[7:4]}; // RULE7
                    f = first_lane(s.be, 3'd0); // RULE8
                    if (f[2]) begin
                        next_s.phase = IDLE_REST;
                    end else begin
                        next_s.lane     = f[1:0];
                        next_s.phase    = REG_DATA;
                        next_s.out_byte = reg_read({s.addr[5:4], nb[7:4], f[1:0]},
                                                   c.transmit_control_reg, c.stat, c.receive_queue_command_reg);
                    end
                end
                REG_DATA: begin
                    ba = {s.addr, s.lane};
                    if (s.op == OP_REG_WRITE) begin
                        if (ba[7:1] == TX_CONTROL_OFFSET[7:1]) begin
                            if (ba[0]) next_c.transmit_control_reg[15:8] = nb;
                            else next_c.transmit_control_reg[7:0] = nb;
                        end else if (ba[7:1] == RXQ_COMMAND_OFFSET[7:1]) begin
                            if (ba[0]) next_c.receive_queue_command_reg[15:8] = nb;
                            else next_c.receive_queue_command_reg[7:0] = nb;
                        end
                    end
                    f = first_lane(s.be, {1'b0, s.lane} + 3'd1); // RULE9 RULE8
                    if (f[2]) begin
                        next_s.phase = IDLE_REST;
                    end else begin
                        next_s.lane     = f[1:0];
                        next_s.out_byte = reg_read({s.addr, f[1:0]}, c.transmit_control_reg, c.stat, c.receive_queue_command_reg);
                    end
                end
                QUEUE_DATA: begin
                    if (s.op == OP_TXQ_WRITE && start) begin // RULE12
                        next_c.wr_byte = nb;
                        next_c.wr_tog  = ~c.wr_tog;
                    end
                    if (s.op == OP_RXQ_READ && start) begin
                        next_s.out_byte = q.rx_stage;
                        next_c.take_tog = ~c.take_tog;
                    end
                end
                default: begin
                    next_s.phase = IDLE_REST;
                end
            endcase
        end
        next_p.so    = s.out_byte[~s.bit_cnt]; // RULE2
        next_p.so_oe = 1'b1;
    end

    always_ff @(posedge SCLK or posedge SYS_RST or posedge CS_N) begin
        if (SYS_RST || CS_N) begin
            s <= '{phase: CMD_HI, default: '0}; // RULE3 RULE23
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge SCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            c <= '{transmit_control_reg: TX_CONTROL_RESET, receive_queue_command_reg: RXQ_COMMAND_RESET, stat: TX_STATUS_RESET,
                   default: '0};
        end else begin
            c <= next_c;
        end
    end

    always_ff @(negedge SCLK or posedge SYS_RST or posedge CS_N) begin
        if (SYS_RST || CS_N) begin
            p <= '0;
        end else begin
            p <= next_p; // RULE2
        end
    end

    // system clock domain
    always_comb begin
        logic [31:0] crc_out;
        logic [POS_WIDTH-1:0] data_end;
        next_q      = q;
        next_q.wt1  = c.wr_tog;
        next_q.wt2  = q.wt1;
        next_q.wt3  = q.wt2;
        next_q.tk1  = c.take_tog;
        next_q.tk2  = q.tk1;
        next_q.tk3  = q.tk2;
        next_q.crc1 = c.transmit_control_reg[CRC_ENABLE_BIT];
        next_q.crc2 = q.crc1;
        next_q.irq  = 1'b0;
        crc_out     = ~q.crc;
        data_end    = POS_WIDTH'(q.len) + POS_WIDTH'(HEADER_BYTES);
        // a full queue drops further bytes; the host is bounded by queue size
        tx_wr = (q.wt3 != q.wt2) && (q.tx_cnt != (TAW+1)'(TXQ_DEPTH)); // RULE11 RULE16
        tx_rd = 1'b0;
        if (tx_wr) begin
            next_q.tx_wp = (q.tx_wp == TAW'(TXQ_DEPTH - 1)) ? '0 : q.tx_wp + 1'b1;
        end
        case (q.tx_state)
            TX_FETCH: begin
                if (q.tx_cnt != '0) begin
                    tx_rd           = 1'b1;
                    next_q.tx_rp    = (q.tx_rp == TAW'(TXQ_DEPTH - 1)) ? '0 : q.tx_rp + 1'b1;
                    next_q.tx_state = TX_USE;
                end
            end
            TX_USE: begin
                next_q.pos      = q.pos + 1'b1;
                next_q.tx_state = TX_FETCH;
                case (q.pos)
                    12'h000: begin
                        next_q.ctrl[7:0] = tx_rdata; // RULE14 RULE18
                        next_q.crc       = CRC_INIT;
                    end
                    12'h001: next_q.ctrl[15:8] = tx_rdata;
                    12'h002: next_q.len[7:0] = tx_rdata; // RULE21
                    12'h003: next_q.len[LENGTH_WIDTH-1:8] = tx_rdata[LENGTH_WIDTH-9:0];
                    default: begin
                        next_q.tx_byte  = tx_rdata; // RULE22
                        next_q.tx_valid = 1'b1;
                        next_q.tx_last  = (q.pos + 1'b1 == data_end) && !q.crc2;
                        next_q.crc      = crc_byte(q.crc, tx_rdata);
                        next_q.tx_state = TX_SEND;
                    end
                endcase
            end
            TX_SEND: begin
                if (TX_BYTE_READY) begin
                    next_q.tx_valid = 1'b0;
                    next_q.tx_last  = 1'b0;
                    if (q.pos != data_end) begin
                        next_q.tx_state = TX_FETCH;
                    end else if (q.crc2) begin
                        next_q.tx_byte  = crc_out[7:0]; // RULE15
                        next_q.tx_valid = 1'b1;
                        next_q.crc_idx  = 2'd0;
                        next_q.tx_state = TX_CRC;
                    end else begin
                        next_q.tx_state = TX_FETCH;
                        next_q.pos      = '0;
                        next_q.stat     = '0;
                        next_q.stat[STATUS_DONE_BIT] = 1'b1;
                        next_q.stat[TAG_WIDTH-1:0]   = q.ctrl[TAG_WIDTH-1:0]; // RULE20
                        next_q.stat_tog = ~q.stat_tog; // RULE16 RULE17
                        next_q.irq      = q.ctrl[IRQ_ON_DONE_BIT]; // RULE19
                    end
                end
            end
            TX_CRC: begin
                if (TX_BYTE_READY) begin
                    next_q.crc_idx = q.crc_idx + 2'd1;
                    next_q.tx_byte = crc_out[{q.crc_idx + 2'd1, 3'b000} +: 8]; // RULE15
                    next_q.tx_last = (q.crc_idx == 2'd2);
                    if (q.crc_idx == 2'd3) begin
                        next_q.tx_valid = 1'b0;
                        next_q.tx_last  = 1'b0;
                        next_q.tx_state = TX_FETCH;
                        next_q.pos      = '0;
                        next_q.stat     = '0;
                        next_q.stat[STATUS_DONE_BIT] = 1'b1;
                        next_q.stat[TAG_WIDTH-1:0]   = q.ctrl[TAG_WIDTH-1:0]; // RULE20
                        next_q.stat_tog = ~q.stat_tog; // RULE17
                        next_q.irq      = q.ctrl[IRQ_ON_DONE_BIT]; // RULE19
                    end
                end
            end
            default: next_q.tx_state = TX_FETCH;
        endcase
        next_q.tx_cnt = q.tx_cnt + (TAW+1)'(tx_wr) - (TAW+1)'(tx_rd);

        // receive queue: mac fills it, one staged byte waits for the link
        rx_wr = RX_BYTE_VALID && q.rx_room; // RULE13
        rx_rd = !q.rx_full && !q.rx_pend && (q.rx_cnt != '0);
        if (rx_wr) begin
            next_q.rx_wp = (q.rx_wp == RAW'(RXQ_DEPTH - 1)) ? '0 : q.rx_wp + 1'b1;
        end
        if (q.tk3 != q.tk2) begin
            next_q.rx_full = 1'b0;
        end
        if (rx_rd) begin
            next_q.rx_rp   = (q.rx_rp == RAW'(RXQ_DEPTH - 1)) ? '0 : q.rx_rp + 1'b1;
            next_q.rx_pend = 1'b1;
        end
        if (q.rx_pend) begin
            next_q.rx_stage = rx_rdata;
            next_q.rx_full  = 1'b1;
            next_q.rx_pend  = 1'b0;
        end
        next_q.rx_cnt  = q.rx_cnt + (RAW+1)'(rx_wr) - (RAW+1)'(rx_rd);
        next_q.rx_room = next_q.rx_cnt < (RAW+1)'(RXQ_DEPTH - 1);
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= '{tx_state: TX_FETCH, stat: TX_STATUS_RESET, default: '0};
        end else begin
            q <= next_q;
        end
    end

    queue_mem #(.DEPTH(TXQ_DEPTH), .WIDTH(8), .AW(TAW)) tx_queue_mem ( // RULE13
        .clk   (CLK),
        .we    (tx_wr),
        .waddr (q.tx_wp),
        .wdata (c.wr_byte),
        .raddr (q.tx_rp),
        .rdata (tx_rdata)
    );

    queue_mem #(.DEPTH(RXQ_DEPTH), .WIDTH(8), .AW(RAW)) rx_queue_mem ( // RULE13
        .clk   (CLK),
        .we    (rx_wr),
        .waddr (q.rx_wp),
        .wdata (RX_BYTE),
        .raddr (q.rx_rp),
        .rdata (rx_rdata)
    );

    assign SO                  = p.so;
    assign SO_OE               = p.so_oe;
    assign RX_ROOM             = q.rx_room;
    assign TX_BYTE             = q.tx_byte;
    assign TX_BYTE_VALID       = q.tx_valid;
    assign TX_BYTE_LAST        = q.tx_last;
    assign TX_DONE_IRQ_REQUEST = q.irq;

endmodule : spi_slave_queue_access

// ---- spi_queue_pkg.sv ----
/*
 * Shared constants and types for the serial queue-access port: opcodes,
 * register offsets and bit positions, queue sizes, frame layout and CRC.
 * Assumes spi_slave_queue_access and the testbench import it whole.
 */
package spi_queue_pkg;

    localparam logic [1:0]  OP_REG_READ        = 2'h0;
    localparam logic [1:0]  OP_REG_WRITE       = 2'h1;
    localparam logic [1:0]  OP_RXQ_READ        = 2'h2;
    localparam logic [1:0]  OP_TXQ_WRITE       = 2'h3;

    localparam logic [7:0]  TX_CONTROL_OFFSET  = 8'h70;
    localparam logic [7:0]  TX_STATUS_OFFSET   = 8'h72;
    localparam logic [7:0]  RXQ_COMMAND_OFFSET = 8'h82;
    localparam logic [15:0] TX_CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] RXQ_COMMAND_RESET  = 16'h0000;
    localparam logic [15:0] TX_STATUS_RESET    = 16'h0000;
    localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

    localparam int          CRC_ENABLE_BIT     = 1;
    localparam int          START_ACCESS_BIT   = 3;
    localparam int          IRQ_ON_DONE_BIT    = 15;
    localparam int          STATUS_DONE_BIT    = 15;
    localparam int          TAG_WIDTH          = 6;
    localparam int          LENGTH_WIDTH       = 11;

    localparam int          RXQ_BYTES          = 12288;
    localparam int          TXQ_BYTES          = 6144;
    localparam int          MAX_FRAME_BYTES    = 2000;
    localparam int          HEADER_BYTES       = 4;
    localparam int          POS_WIDTH          = 12;

    localparam logic [31:0] CRC_POLY           = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT           = 32'hFFFF_FFFF;

    typedef enum logic [2:0] {CMD_HI, CMD_LO, REG_DATA, QUEUE_DATA, IDLE_REST} spi_phase_t;
    typedef enum logic [1:0] {TX_FETCH, TX_USE, TX_SEND, TX_CRC} tx_state_t;

    // reflected ethernet crc, one byte, lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] data);
        logic [31:0] c;
        c = crc ^ {24'h00_0000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

endpackage : spi_queue_pkg

// ---- queue_mem.sv ----
/*
 * Simple dual-port byte memory for one packet queue, registered read data.
 * Assumes one clock for both ports and that the caller never reads an
 * address in the cycle it is written.
 */
`timescale 1ns/1ns
module queue_mem #(
    parameter int DEPTH = 6144,
    parameter int WIDTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output      logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : queue_mem

// ---- spi_slave_queue_access_properties.sv ----
/* pin-level assertions for the serial queue port and its mac side
   assumes binding into spi_slave_queue_access */
`timescale 1ns/1ns
module spi_queue_checker #(
    parameter int TXQ_DEPTH = 6144,
    parameter int RXQ_DEPTH = 12288
) (
    input wire logic       CLK,
    input wire logic       SYS_RST,
    input wire logic       SCLK,
    input wire logic       CS_N,
    input wire logic       SO_OE,
    input wire logic [7:0] TX_BYTE,
    input wire logic       TX_BYTE_VALID,
    input wire logic       TX_BYTE_LAST,
    input wire logic       TX_BYTE_READY,
    input wire logic       TX_DONE_IRQ_REQUEST
);
    logic [1:0] rises;
    logic [3:0] since_last;
    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) rises <= 2'h0;
        else if (rises != 2'h3) rises <= rises + 2'h1;
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) since_last <= 4'hf;
        else if (TX_BYTE_VALID && TX_BYTE_READY && TX_BYTE_LAST) since_last <= 4'h0;
        else if (since_last != 4'hf) since_last <= since_last + 4'h1;
    end
    sequence s_wait;
        TX_BYTE_VALID && !TX_BYTE_READY;
    endsequence
    sequence s_taken;
        TX_BYTE_VALID && TX_BYTE_READY;
    endsequence
    a_oe_released: assert property (@(posedge CLK) disable iff (SYS_RST)
        CS_N [*2] |-> !SO_OE) else $error("oe outside frame");
    a_oe_first_rise: assert property (@(posedge SCLK) disable iff (SYS_RST)
        rises == 2'h0 |-> !SO_OE) else $error("oe before first fall");
    a_oe_driving: assert property (@(posedge SCLK) disable iff (SYS_RST)
        !CS_N && rises != 2'h0 |-> SO_OE) else $error("output not driven in frame");
    a_valid_holds: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_wait |=> TX_BYTE_VALID && $stable(TX_BYTE) && $stable(TX_BYTE_LAST))
        else $error("mac byte changed");
    a_valid_drop: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_taken && TX_BYTE_LAST |=> !TX_BYTE_VALID) else $error("mac byte not refetched");
    a_last_valid: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_BYTE_LAST |-> TX_BYTE_VALID) else $error("last flag without byte");
    a_irq_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_DONE_IRQ_REQUEST |=> !TX_DONE_IRQ_REQUEST) else $error("done pulse too long");
    a_irq_after_end: assert property (@(posedge CLK) disable iff (SYS_RST)
        TX_DONE_IRQ_REQUEST |-> since_last != 4'hf) else $error("stray done pulse");
endmodule : spi_queue_checker
bind spi_slave_queue_access spi_queue_checker #(.TXQ_DEPTH(TXQ_DEPTH), .RXQ_DEPTH(RXQ_DEPTH))
    i_spi_queue_checker (.*);

// ---- spi_host_model.sv ----
/* serial master: mode 0, msb first, framed by chip select
   assumes the bench calls one task at a time; hp sets the pace */
`timescale 1ns/1ns
module spi_host_model (
    output logic      SCLK,
    output logic      CS_N,
    output logic      SI,
    input  wire logic SO
);
    int hp = 15;
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
    end
    task automatic frame_open();
        CS_N = 1'b0;
        #(hp);
    endtask : frame_open
    task automatic frame_close();
        #(hp);
        CS_N = 1'b1;
        #(2 * hp);
    endtask : frame_close
    task automatic xbyte(input logic [7:0] o, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            SI = o[i];
            #(hp);
            SCLK = 1'b1;
            r[i] = SO;
            #(hp);
            SCLK = 1'b0;
        end
    endtask : xbyte
endmodule : spi_host_model

// ---- testbench.sv ----
/* self-checking bench: registers, both queues and the mac side
   assumes small queue depths and a 30 ns serial clock */
`timescale 1ns/1ns
module testbench;
    import spi_queue_pkg::*;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [7:0]  RX_BYTE = 8'h00;
    logic        RX_BYTE_VALID = 1'b0;
    logic        TX_BYTE_READY = 1'b0;
    logic        SCLK, CS_N, SI, SO, SO_OE, so_line, RX_ROOM;
    logic        TX_BYTE_VALID, TX_BYTE_LAST, TX_DONE_IRQ_REQUEST;
    logic [7:0]  TX_BYTE;
    logic [31:0] seed = 32'h0000_0005;
    int          err_total, check_count, cyc, irqs, exp_irqs;
    logic [7:0]  exp_rx[$], mdl[0:255];
    logic [9:0]  exp_tx[$];
    logic [8:0]  got_tx[$];
    always #20 CLK = ~CLK;
    assign so_line = SO_OE ? SO : 1'bz;
    spi_slave_queue_access #(.TXQ_DEPTH(64), .RXQ_DEPTH(128)) i_spi_slave_queue_access (.*);
    spi_host_model i_spi_host_model (.SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(so_line));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    always @(negedge CLK) begin
        seed = xs();
        if (!SYS_RST) begin
            RX_BYTE = seed[7:0];
            RX_BYTE_VALID = seed[8];
            TX_BYTE_READY = seed[9] | seed[10];
            if (RX_BYTE_VALID && RX_ROOM) exp_rx.push_back(RX_BYTE);
            if (TX_BYTE_VALID && TX_BYTE_READY) got_tx.push_back({TX_BYTE_LAST, TX_BYTE});
            if (TX_DONE_IRQ_REQUEST === 1'b1) irqs++;
        end
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            final_report();
        end
    end
    task automatic reg_acc(input logic wr, input logic [3:0] be, input logic [7:0] a,
                           input logic [31:0] d);
        logic [7:0] r;
        logic [7:0] ba;
        i_spi_host_model.frame_open();
        i_spi_host_model.xbyte({1'b0, wr, be, a[7:6]}, r);
        i_spi_host_model.xbyte({a[5:2], 4'h0}, r);
        for (int k = 0; k < 4; k++) begin
            ba = {a[7:2], 2'(k)};
            if (be[k]) begin
                i_spi_host_model.xbyte(d[8*k+:8], r);
                if (!wr) chk("register byte", 16'(mdl[ba]), 16'(r));
                else if (ba inside {8'h70, 8'h71, 8'h82, 8'h83}) mdl[ba] = d[8*k+:8];
            end
        end
        i_spi_host_model.frame_close();
    endtask : reg_acc
    task automatic txq_frame(input logic [15:0] ctl, input int n);
        logic [7:0]  r;
        logic [7:0]  b;
        logic [31:0] hdr;
        logic        on;
        logic        crc;
        hdr = {16'(n), ctl};
        on = mdl[8'h82][START_ACCESS_BIT];
        crc = mdl[8'h70][CRC_ENABLE_BIT];
        for (int k = 0; k < 4; k++) i_spi_host_model.xbyte(hdr[8*k+:8], r);
        for (int k = 0; k < n; k++) begin
            b = 8'(xs());
            i_spi_host_model.xbyte(b, r);
            if (on) exp_tx.push_back({1'b0, k == n - 1 && !crc, b});
        end
        for (int k = 0; k < 4; k++) if (on && crc) exp_tx.push_back({1'b1, k == 3, 8'h00});
        if (on) {mdl[8'h73], mdl[8'h72]} = {8'h80, 2'h0, ctl[5:0]};
        if (on) exp_irqs += ctl[15];
    endtask : txq_frame
    task automatic txq_send(input logic [15:0] c0, input int n0, input logic [15:0] c1,
                            input int n1);
        logic [7:0] r;
        i_spi_host_model.frame_open();
        i_spi_host_model.xbyte(8'hc0, r);
        txq_frame(c0, n0);
        if (n1 > 0) txq_frame(c1, n1);
        i_spi_host_model.frame_close();
    endtask : txq_send
    initial begin
        logic [7:0] r;
        logic [9:0] e;
        logic [8:0] g;
        for (int i = 0; i < 256; i++) mdl[i] = UNMAPPED_READ;
        {mdl[8'h71], mdl[8'h70]} = TX_CONTROL_RESET;
        {mdl[8'h73], mdl[8'h72]} = TX_STATUS_RESET;
        {mdl[8'h83], mdl[8'h82]} = RXQ_COMMAND_RESET;
        repeat (10) @(negedge CLK);
        SYS_RST = 1'b0;
        repeat (3) @(negedge CLK);
        reg_acc(1'b0, 4'hf, 8'h70, 32'h0);
        reg_acc(1'b0, 4'h1, 8'h40, 32'h0);
        reg_acc(1'b1, 4'h7, 8'h70, 32'h00aa_0000);
        reg_acc(1'b0, 4'hf, 8'h70, 32'h0);
        txq_send(16'h8001, 8, 16'h0, 0);
        reg_acc(1'b1, 4'hc, 8'h80, 32'h0008_0000);
        i_spi_host_model.hp = 60;
        reg_acc(1'b0, 4'hc, 8'h80, 32'h0);
        i_spi_host_model.hp = 15;
        txq_send(16'h8005, 5, 16'h0013, 12);
        reg_acc(1'b1, 4'h1, 8'h70, 32'h0000_0002);
        txq_send(16'h8021, 3, 16'h0, 0);
        for (int i = 0; i < 3000 && got_tx.size() < exp_tx.size(); i++) @(negedge CLK);
        repeat (4) @(negedge CLK);
        chk("mac byte count", 16'(exp_tx.size()), 16'(got_tx.size()));
        while (exp_tx.size() > 0 && got_tx.size() > 0) begin
            e = exp_tx.pop_front();
            g = got_tx.pop_front();
            if (e[9]) e[7:0] = g[7:0];
            chk("mac byte", 16'(e[8:0]), 16'(g));
        end
        chk("done pulses", 16'(exp_irqs), 16'(irqs));
        reg_acc(1'b0, 4'hc, 8'h70, 32'h0);
        i_spi_host_model.hp = 30;
        i_spi_host_model.frame_open();
        i_spi_host_model.xbyte(8'h80, r);
        repeat (20) begin
            i_spi_host_model.xbyte(8'h00, r);
            chk("receive byte", 16'(exp_rx.pop_front()), 16'(r));
        end
        i_spi_host_model.frame_close();
        reg_acc(1'b1, 4'h4, 8'h80, 32'h0);
        final_report();
    end
endmodule : testbench
